// ===== hw/fup_pkg.sv
package fup_pkg;

  // Command codes written to the flash control register
  localparam logic [7:0] KEY_FIRST = 8'h73;
  localparam logic [7:0] KEY_UNLOCK = 8'h8c;
  localparam logic [7:0] KEY_SECTOR = 8'h5e;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;

  // Geometry defaults
  localparam int PAGE_W = 8;
  localparam int SECT_N = 8;
  localparam int BYTE_W = 7;
  localparam logic [SECT_N-1:0] SECT_RESET = 8'h00;

  // Option bytes sit at the first two program addresses
  localparam logic [15:0] OPT_ADDR0 = 16'h0000;
  localparam logic [15:0] OPT_ADDR1 = 16'h0001;
  localparam int OPT_BYTES = 2;
  // Bit of option byte 0 that holds the global write-protect flag
  localparam int OPT_WP_BIT = 7;

  // Loader start index
  localparam logic [1:0] LOAD_IDX0 = 2'h0;

  // Command bus from the CPU side
  typedef struct packed {
    logic ctl_we;
    logic psel_we;
    logic [7:0] wdata;
  } fup_cpu_wr_t;

  // Program/erase strobe toward the array
  typedef struct packed {
    logic prog;
    logic erase;
    logic [PAGE_W-1:0] page;
    logic [BYTE_W-1:0] offs;
    logic [7:0] data;
  } fup_arr_cmd_t;

  typedef enum logic [4:0] {
    ST_LOCKED = 5'b00001,
    ST_KEY1 = 5'b00010,
    ST_CONFIRM = 5'b00100,
    ST_ACTIVE = 5'b01000,
    ST_SECT = 5'b10000
  } fup_state_t;

endpackage

// ===== hw/fup_opt_loader.sv
`timescale 1ns/1ns
// Reads option bytes from program memory while the device is held in reset
module fup_opt_loader #(
  parameter int NBYTES = fup_pkg::OPT_BYTES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] opt_byte0,
  output logic [7:0] opt_byte1,
  output logic load_done
);

  logic [1:0] idx;
  logic [1:0] next_idx;
  logic [7:0] next_opt0;
  logic [7:0] next_opt1;
  logic next_done;
  logic rst_q;
  logic walk;

  ////////////////////////////////////////////////////////////////
  // The first reset edge only re-arms the walk; the address leaves
  // through a flop in the parent, so a byte is taken one cycle after
  // its address is shown and reset must last four edges
  assign walk = rst && rst_q;

  // Loader moves only while reset is held, so a change to the option
  // bytes takes effect at the next reset and never live
  always_comb begin
    next_idx = idx;
    next_opt0 = opt_byte0;
    next_opt1 = opt_byte1;
    next_done = load_done;
    if (walk) begin
      if (!load_done) begin
        if (idx == 2'h1) next_opt0 = mem_rdata;
        if (idx == 2'h2) next_opt1 = mem_rdata;
        if (idx == 2'(NBYTES)) begin
          next_done = 1'b1;
        end else begin
          next_idx = idx + 2'h1;
        end
      end
    end else begin
      next_idx = fup_pkg::LOAD_IDX0;
      next_done = 1'b0;
    end
  end

  // Plain registers; rst_q remembers last cycle's reset to find its start
  always_ff @(posedge mclk) begin
    rst_q <= rst;
    idx <= next_idx;
    opt_byte0 <= next_opt0;
    opt_byte1 <= next_opt1;
    load_done <= next_done;
  end

  assign mem_addr = (idx == 2'h0) ? fup_pkg::OPT_ADDR0 : fup_pkg::OPT_ADDR1;

endmodule // fup_opt_loader

// ===== hw/fup_sector_map.sv
`timescale 1ns/1ns
// Maps a page to its protection sector
module fup_sector_map #(
  parameter int PAGE_W = fup_pkg::PAGE_W,
  parameter int SECT_N = fup_pkg::SECT_N
) (
  input wire logic [PAGE_W-1:0] page,
  input wire logic [SECT_N-1:0] protect,
  output logic page_protected
);

  localparam int SECT_W = $clog2(SECT_N);

  // Top bits of the page pick the sector; with fewer pages than
  // sectors a sector shrinks to one page
  logic [SECT_W-1:0] sect;
  generate
    if (PAGE_W >= SECT_W) begin : g_wide
      assign sect = page[PAGE_W-1 -: SECT_W];
    end else begin : g_narrow
      assign sect = SECT_W'(page);
    end
  endgenerate

  assign page_protected = protect[sect];

endmodule // fup_sector_map

// ===== hw/fup_ctrl.sv
`timescale 1ns/1ns
module fup_ctrl #(
  parameter int PAGE_W = fup_pkg::PAGE_W,
  parameter int SECT_N = fup_pkg::SECT_N,
  parameter int BYTE_W = fup_pkg::BYTE_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fup_pkg::fup_cpu_wr_t cpu_wr,
  input wire logic byte_we,
  input wire logic [PAGE_W-1:0] byte_page,
  input wire logic [BYTE_W-1:0] byte_offs,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] opt_rdata,
  output logic [15:0] opt_addr,
  output fup_pkg::fup_arr_cmd_t arr_cmd,
  output logic unlocked,
  output logic [PAGE_W-1:0] active_page,
  output logic [SECT_N-1:0] sector_protect,
  output logic refused,
  output logic cpu_hold
);

  fup_pkg::fup_state_t state;
  fup_pkg::fup_state_t next_state;
  logic [PAGE_W-1:0] page_sel;
  logic [PAGE_W-1:0] next_page_sel;
  logic [SECT_N-1:0] next_protect;
  fup_pkg::fup_arr_cmd_t next_cmd;
  logic next_refused;
  logic [7:0] opt0;
  logic [7:0] opt1;
  logic [15:0] opt_addr_w;
  logic page_prot;
  logic wp_ok;

  ////////////////////////////////////////////////////////////////
  // Option bytes live in private flops; nothing on the CPU side can
  // reach them, only the enable they produce
  fup_opt_loader #(
    .NBYTES(fup_pkg::OPT_BYTES)
  ) u_loader (
    .mclk(mclk),
    .rst(rst),
    .mem_rdata(opt_rdata),
    .mem_addr(opt_addr_w),
    .opt_byte0(opt0),
    .opt_byte1(opt1),
    .load_done()
  );

  // Global write-protect option: 1 lets user code program and erase
  assign wp_ok = opt0[fup_pkg::OPT_WP_BIT];

  fup_sector_map #(
    .PAGE_W(PAGE_W),
    .SECT_N(SECT_N)
  ) u_map (
    .page(page_sel),
    .protect(sector_protect),
    .page_protected(page_prot)
  );

  ////////////////////////////////////////////////////////////////
  // Unlock sequencer: one control or page-select write per step
  always_comb begin
    next_state = state;
    next_page_sel = page_sel;
    next_protect = sector_protect;
    next_cmd = '0;
    next_refused = 1'b0;
    unique case (state)
      fup_pkg::ST_LOCKED: begin
        if (cpu_wr.psel_we) next_page_sel = cpu_wr.wdata[PAGE_W-1:0];
        if (cpu_wr.ctl_we) begin
          if (cpu_wr.wdata == fup_pkg::KEY_FIRST) begin
            next_state = fup_pkg::ST_KEY1;
          end else begin
            next_refused = (cpu_wr.wdata == fup_pkg::CMD_PAGE_ERASE);
          end
        end
        if (byte_we) next_refused = 1'b1;
      end
      fup_pkg::ST_KEY1: begin
        // A page-select write here breaks the back-to-back key pair
        if (cpu_wr.psel_we) next_state = fup_pkg::ST_LOCKED;
        if (cpu_wr.ctl_we) begin
          if (cpu_wr.wdata == fup_pkg::KEY_UNLOCK) begin
            next_state = fup_pkg::ST_CONFIRM;
          end else if (cpu_wr.wdata == fup_pkg::KEY_SECTOR) begin
            next_state = fup_pkg::ST_SECT;
          end else begin
            next_state = fup_pkg::ST_LOCKED;
          end
        end
        if (byte_we) next_refused = 1'b1;
      end
      fup_pkg::ST_CONFIRM: begin
        if (cpu_wr.psel_we) begin
          if (cpu_wr.wdata[PAGE_W-1:0] == page_sel) begin
            next_state = fup_pkg::ST_ACTIVE;
          end else begin
            next_state = fup_pkg::ST_LOCKED;
          end
        end
        if (cpu_wr.ctl_we) next_state = fup_pkg::ST_LOCKED;
        if (byte_we) next_refused = 1'b1;
      end
      fup_pkg::ST_ACTIVE: begin
        if (cpu_wr.ctl_we) begin
          // Erase or not, any control write closes the page
          next_state = fup_pkg::ST_LOCKED;
          if (cpu_wr.wdata == fup_pkg::CMD_PAGE_ERASE) begin
            if (!page_prot && wp_ok) begin
              next_cmd.erase = 1'b1;
              next_cmd.page = page_sel;
            end else begin
              next_refused = 1'b1;
            end
          end
          // Other codes, mass erase among them, only relock
        end else if (byte_we) begin
          // Bytes outside the active page are dropped, page stays open
          if (byte_page == page_sel && !page_prot && wp_ok) begin
            next_cmd.prog = 1'b1;
            next_cmd.page = page_sel;
            next_cmd.offs = byte_offs;
            next_cmd.data = byte_data;
          end else begin
            next_refused = 1'b1;
          end
        end
        if (cpu_wr.psel_we && !cpu_wr.ctl_we) next_page_sel = page_sel;
      end
      fup_pkg::ST_SECT: begin
        // Shared address: this write lands in protection, not page select
        if (cpu_wr.psel_we) begin
          next_protect = sector_protect | cpu_wr.wdata[SECT_N-1:0];
          next_state = fup_pkg::ST_LOCKED;
        end
        if (cpu_wr.ctl_we) next_state = fup_pkg::ST_LOCKED;
        if (byte_we) next_refused = 1'b1;
      end
      default: begin
        next_state = fup_pkg::ST_LOCKED;
      end
    endcase
  end

  // Protection bits only set; a cleared bit needs a reset, so a rogue
  // write cannot quietly reopen a sector
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= fup_pkg::ST_LOCKED;
      page_sel <= '0;
      sector_protect <= fup_pkg::SECT_RESET;
      arr_cmd <= '0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      page_sel <= next_page_sel;
      sector_protect <= next_protect;
      arr_cmd <= next_cmd;
      refused <= next_refused;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status and CPU hold, all registered; the option address runs free
  // so the loader can step it while reset is held
  always_ff @(posedge mclk) begin
    opt_addr <= opt_addr_w;
    if (rst) begin
      unlocked <= 1'b0;
      active_page <= '0;
      cpu_hold <= 1'b1;
    end else begin
      unlocked <= (next_state == fup_pkg::ST_ACTIVE);
      active_page <= next_page_sel;
      cpu_hold <= 1'b0;
    end
  end

endmodule // fup_ctrl

// ===== verification/fup_ctrl_props.sv
`timescale 1ns/1ns
// Ties each lock, command and protection output to the request that caused it
module fup_ctrl_props #(
  parameter int PAGE_W = 8,
  parameter int SECT_N = 8,
  parameter int BYTE_W = 7
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fup_pkg::fup_cpu_wr_t cpu_wr,
  input wire logic byte_we,
  input wire logic [PAGE_W-1:0] byte_page,
  input wire logic [BYTE_W-1:0] byte_offs,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] opt_rdata,
  input wire logic [15:0] opt_addr,
  input wire fup_pkg::fup_arr_cmd_t arr_cmd,
  input wire logic unlocked,
  input wire logic [PAGE_W-1:0] active_page,
  input wire logic [SECT_N-1:0] sector_protect,
  input wire logic refused,
  input wire logic cpu_hold
);
  localparam int SB = $clog2(SECT_N);
  ////////////////////////////////////////////////////////////////////////////////
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_PROG_OPEN:
    assert property (arr_cmd.prog |-> $past(unlocked) && $past(byte_we)) else $error("prog without open page");
  AST_PROG_PAGE:
    assert property (arr_cmd.prog |-> arr_cmd.page == $past(active_page) && arr_cmd.offs == $past(byte_offs))
      else $error("prog page or offset wrong");
  AST_CTL_RELOCK:
    assert property ($past(cpu_wr.ctl_we) && $past(unlocked) |-> !unlocked) else $error("control write kept page open");
  AST_ERASE_CAUSE:
    assert property (arr_cmd.erase |-> $past(cpu_wr.ctl_we) && $past(unlocked)
      && $past(cpu_wr.wdata) == fup_pkg::CMD_PAGE_ERASE) else $error("erase without erase command");
  AST_PROT_BLOCKS:
    assert property (arr_cmd.prog || arr_cmd.erase |-> !sector_protect[arr_cmd.page[PAGE_W-1 -: SB]])
      else $error("protected sector altered");
  AST_PROT_WRITE:
    assert property ($changed(sector_protect) |-> $past(cpu_wr.psel_we) && !unlocked) else $error("stray protect change");
  AST_REFUSE_QUIET:
    assert property (refused |-> !arr_cmd.prog && !arr_cmd.erase) else $error("refused request reached array");
  AST_OPEN_CAUSE:
    assert property ($rose(unlocked) |-> $past(cpu_wr.psel_we) && active_page == $past(cpu_wr.wdata))
      else $error("page opened without matching confirm");
  AST_STAYS_OPEN:
    assert property (arr_cmd.prog && !$past(cpu_wr.ctl_we) |-> unlocked) else $error("page closed after byte");
endmodule // fup_ctrl_props

bind fup_ctrl fup_ctrl_props #(.PAGE_W(PAGE_W), .SECT_N(SECT_N), .BYTE_W(BYTE_W)) u_props (.mclk(mclk), .rst(rst),
  .cpu_wr(cpu_wr), .byte_we(byte_we), .byte_page(byte_page), .byte_offs(byte_offs), .byte_data(byte_data),
  .opt_rdata(opt_rdata), .opt_addr(opt_addr), .arr_cmd(arr_cmd), .unlocked(unlocked), .active_page(active_page),
  .sector_protect(sector_protect), .refused(refused), .cpu_hold(cpu_hold));

// ===== verification/fup_ctrl_tb_top.sv
`timescale 1ns/1ns
module fup_ctrl_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  fup_pkg::fup_cpu_wr_t cpu_wr = '0;
  logic byte_we = 1'b0;
  logic [7:0] byte_page = 8'h00;
  logic [6:0] byte_offs = 7'h00;
  logic [7:0] byte_data = 8'h00;
  logic [7:0] opt_b = 8'h80;
  logic [15:0] opt_a;
  logic [7:0] opt_rd;
  fup_pkg::fup_arr_cmd_t arr_cmd;
  logic unlocked;
  logic refused;
  logic cpu_hold;
  logic [7:0] active_page;
  logic [7:0] sector_protect;
  int bad_count = 0;
  int checks = 0;
  int seed = 78;
  // Model: 0 locked, 1 first key, 2 confirm, 3 open, 4 protect write
  int st = 0;
  int pg = 0;
  int prot = 0;
  int wpe = 1;
  logic [7:0] p;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, device and option memory; byte 1 is the inverse of byte 0 so a swapped load shows
  always #50 mclk = ~mclk;
  assign opt_rd = (opt_a == 16'h0000) ? opt_b : ~opt_b;
  fup_ctrl u_fup_ctrl (.mclk(mclk), .rst(rst), .cpu_wr(cpu_wr), .byte_we(byte_we), .byte_page(byte_page),
    .byte_offs(byte_offs), .byte_data(byte_data), .opt_rdata(opt_rd), .opt_addr(opt_a), .arr_cmd(arr_cmd),
    .unlocked(unlocked), .active_page(active_page), .sector_protect(sector_protect), .refused(refused),
    .cpu_hold(cpu_hold));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reset for five edges; the model picks up the write-protect option here only
  task automatic do_reset();
    if (!rst) @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("cpu_hold", 1, cpu_hold);
    chk("opt_addr", 16'h0001, opt_a);
    st = 0;
    prot = 0;
    wpe = opt_b[7];
    @(posedge mclk);
    #1;
    chk("unlocked", 0, unlocked);
    chk("sector_protect", 0, sector_protect);
    chk("cpu_hold", 0, cpu_hold);
  endtask
  // One request (0 control, 1 page select, 2 byte), then compare all results
  task automatic op(input int k, input logic [7:0] d, input logic [7:0] bp = 8'h00);
    logic [6:0] o;
    int ok;
    int ep;
    int er;
    int ee;
    o = 7'($random(seed));
    ok = wpe && !prot[pg[7:5]];
    ep = 0;
    er = 0;
    ee = 0;
    @(posedge mclk);
    cpu_wr.ctl_we <= (k == 0);
    cpu_wr.psel_we <= (k == 1);
    cpu_wr.wdata <= d;
    byte_we <= (k == 2);
    byte_page <= bp;
    byte_offs <= o;
    byte_data <= d;
    @(posedge mclk);
    cpu_wr <= '0;
    byte_we <= 1'b0;
    if (k == 2) begin
      if (st == 3 && bp == pg && ok) ep = 1; else er = 1;
    end else if (k == 1) begin
      if (st == 0) pg = d;
      else if (st == 1) st = 0;
      else if (st == 2) st = (d == pg) ? 3 : 0;
      else if (st == 4) begin
        prot = prot | d;
        st = 0;
      end
    end else begin
      if (d == 8'h95) begin
        if (st == 3 && ok) ee = 1; else if (st == 3 || st == 0) er = 1;
      end
      st = (st == 0 && d == 8'h73) ? 1 : (st == 1 && d == 8'h8c) ? 2 : (st == 1 && d == 8'h5e) ? 4 : 0;
    end
    #1;
    chk("unlocked", st == 3, unlocked);
    chk("prog", ep, arr_cmd.prog);
    chk("erase", ee, arr_cmd.erase);
    chk("refused", er, refused);
    chk("sector_protect", prot, sector_protect);
    if (st == 3) chk("active_page", pg, active_page);
    if (ep) chk("prog_fields", {bp, o, d}, {arr_cmd.page, arr_cmd.offs, arr_cmd.data});
    if (ee) chk("erase_page", pg, arr_cmd.page);
  endtask
  task automatic unlock(input logic [7:0] pp);
    op(1, pp);
    op(0, 8'h73);
    op(0, 8'h8c);
    op(1, pp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    op(2, 8'h5a, 8'h10);
    for (int i = 0; i < 4; i++) begin
      p = 8'($random(seed));
      unlock(p);
      op(2, 8'($random(seed)), p);
      op(2, 8'($random(seed)), p);
      op(2, 8'h11, p ^ 8'h01);
      op(0, 8'($random(seed)) & 8'hf0);
    end
    op(1, 8'h20);
    op(0, 8'h73);
    op(0, 8'h8c);
    op(1, 8'h21);
    op(2, 8'h33, 8'h20);
    op(1, 8'h20);
    op(0, 8'h73);
    op(0, 8'h11);
    op(0, 8'h8c);
    op(0, 8'h95);
    op(0, 8'h73);
    op(1, 8'h20);
    op(0, 8'h8c);
    unlock(8'h44);
    op(0, 8'h95);
    op(0, 8'h73);
    op(0, 8'h5e);
    op(1, 8'h04);
    unlock(8'h44);
    op(2, 8'h66, 8'h44);
    op(0, 8'h95);
    unlock(8'h20);
    op(2, 8'h77, 8'h20);
    opt_b = 8'h7f;
    do_reset();
    unlock(8'h20);
    op(2, 8'h12, 8'h20);
    opt_b = 8'h80;
    op(2, 8'h13, 8'h20);
    op(0, 8'h95);
    do_reset();
    unlock(8'h20);
    op(2, 8'h14, 8'h20);
    conclude();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end
endmodule // fup_ctrl_tb_top
